// *** rtl/sxd_top.sv ***
// descriptor-chained single/dual/quad spi master engine with wishbone registers
// Operation
// - count in bits 31:17, zero runs forever
// - last descriptor sets done on finish
// - successor index bits 15:12, self allowed
// - unit field: bits, bytes, 4B, 16B
// - terminate set on last descriptor: release cs, go idle
// - terminate clear: cs held, stay active
// - rx dma size nonzero requests rx draining
// - rx dma size 1,2,4 bytes; 0 off
// - rx enable stores received data
// - tx dma size nonzero requests tx fill
// - tx select 3 ones, 2 zeros, no fifo
// - tx select 1 shifts fifo data out
// - tx select 0 leaves lines undriven
// - sixteen identical descriptor registers
//
// Local design decision: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module sxd_top (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic             sclk_o,
  output logic             cs_n_o,
  output logic      [3:0]  io_o,
  output logic      [3:0]  io_oe_n_o,
  input  wire logic [3:0]  io_i,
  output logic             tx_dma_req_o,
  output logic             rx_dma_req_o,
  output logic      [1:0]  tx_dma_size_o,
  output logic      [1:0]  rx_dma_size_o,
  input  wire logic        dma_term_i,
  output logic             irq_o
);
  sxd_pkg::sxd_desc_t  desc_r [sxd_pkg::NDESC];
  sxd_pkg::sxd_desc_t  cur;
  sxd_pkg::sxd_state_t state_r;
  logic [3:0]  cur_idx_r;
  logic [3:0]  hcnt_r;
  logic [3:0]  bit_cnt_r;
  logic [21:0] bits_done_r;
  logic [7:0]  tx_sh_r;
  logic [7:0]  rx_sh_r;
  logic [7:0]  tx_data_r;
  logic        tx_full_r;
  logic [7:0]  rx_data_r;
  logic        rx_full_r;
  logic [sxd_pkg::NEV-1:0] stat_r;
  logic [sxd_pkg::NEV-1:0] mask_r;
  logic        ack_r;
  logic [31:0] dat_r;
  logic        rd_took_r;

  // bus decode: one wait state, the access lands on the edge that sees ack
  logic        req;
  logic        acc;
  logic        wr;
  logic [5:0]  wix;
  logic        desc_hit;
  logic        start_p;
  logic        stop_p;
  assign req      = cyc_i & stb_i;
  assign acc      = req & ack_r;
  assign wr       = acc & we_i;
  assign wix      = adr_i[7:2] - sxd_pkg::OFF_DESC0[7:2];
  assign desc_hit = (adr_i[7:2] >= sxd_pkg::OFF_DESC0[7:2]) && (wix < sxd_pkg::NDESC_W);
  assign start_p  = wr && adr_i == sxd_pkg::OFF_CTRL && sel_i[0] && dat_i[sxd_pkg::CTRL_START];
  assign stop_p   = wr && adr_i == sxd_pkg::OFF_CTRL && sel_i[0] && dat_i[sxd_pkg::CTRL_STOP];

  assign cur = desc_r[cur_idx_r];

  // engine datapath terms
  logic [3:0]  step;
  logic [2:0]  ush;
  logic [21:0] total_bits;
  logic [21:0] bits_nxt;
  logic [3:0]  bit_nxt;
  logic        fin;
  logic        byte_end;
  logic        half_end;
  logic        step_end;
  logic        desc_end;
  logic        can_go;
  logic [7:0]  rx_sh_nxt;
  logic [7:0]  tx_sh_nxt;
  logic [7:0]  fill;

  always_comb begin
    case (cur.lanes)
      sxd_pkg::LN_DUAL: begin
        step      = sxd_pkg::STEP2;
        rx_sh_nxt = {rx_sh_r[5:0], io_i[1:0]};
        tx_sh_nxt = {tx_sh_r[5:0], 2'h0};
      end
      sxd_pkg::LN_QUAD: begin
        step      = sxd_pkg::STEP4;
        rx_sh_nxt = {rx_sh_r[3:0], io_i[3:0]};
        tx_sh_nxt = {tx_sh_r[3:0], 4'h0};
      end
      default: begin
        step      = sxd_pkg::STEP1;
        rx_sh_nxt = {rx_sh_r[6:0], io_i[1]};
        tx_sh_nxt = {tx_sh_r[6:0], 1'h0};
      end
    endcase
  end

  always_comb begin
    case (cur.unit)
      sxd_pkg::UNIT_BYTES: ush = sxd_pkg::SH_BYTES;
      sxd_pkg::UNIT_SEG4:  ush = sxd_pkg::SH_SEG4;
      sxd_pkg::UNIT_SEG16: ush = sxd_pkg::SH_SEG16;
      default:             ush = sxd_pkg::SH_BITS;
    endcase
  end

  assign total_bits = {7'h0, cur.count} << ush;
  assign bits_nxt   = bits_done_r + {18'h0, step};
  // a zero count never finishes; only stop or dma termination ends it
  assign fin        = (cur.count != 15'h0) && (bits_nxt >= total_bits);
  assign bit_nxt    = bit_cnt_r + step;
  assign byte_end   = bit_nxt >= sxd_pkg::BYTE_BITS;
  assign half_end   = hcnt_r == sxd_pkg::SCK_HALF - 4'h1;
  assign step_end   = state_r == sxd_pkg::ST_HI && half_end;
  assign desc_end   = step_end && (fin || dma_term_i);
  // a byte only starts with tx data on hand and room for what comes back
  assign can_go     = !(cur.tx_sel == sxd_pkg::TX_FIFO && !tx_full_r) && !(cur.rx_en && rx_full_r);

  always_comb begin
    case (cur.tx_sel)
      sxd_pkg::TX_ONE:  fill = 8'hff;
      sxd_pkg::TX_FIFO: fill = tx_data_r;
      default:          fill = 8'h00;
    endcase
  end

  // serial engine
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r     <= sxd_pkg::ST_IDLE;
      cur_idx_r   <= 4'h0;
      hcnt_r      <= 4'h0;
      bit_cnt_r   <= 4'h0;
      bits_done_r <= 22'h0;
      tx_sh_r     <= 8'h00;
      rx_sh_r     <= 8'h00;
    end else if (stop_p) begin
      state_r <= sxd_pkg::ST_IDLE;
    end else begin
      case (state_r)
        sxd_pkg::ST_IDLE, sxd_pkg::ST_HOLD: begin
          if (start_p) begin
            cur_idx_r   <= dat_i[sxd_pkg::CTRL_IDX_LSB +: 4];
            bits_done_r <= 22'h0;
            bit_cnt_r   <= 4'h0;
            state_r     <= sxd_pkg::ST_LOAD;
          end
        end
        sxd_pkg::ST_LOAD: begin
          if (can_go) begin
            tx_sh_r <= fill;
            hcnt_r  <= 4'h0;
            state_r <= sxd_pkg::ST_LO;
          end
        end
        sxd_pkg::ST_LO: begin
          hcnt_r <= hcnt_r + 4'h1;
          if (half_end) begin
            rx_sh_r <= rx_sh_nxt;
            hcnt_r  <= 4'h0;
            state_r <= sxd_pkg::ST_HI;
          end
        end
        sxd_pkg::ST_HI: begin
          hcnt_r <= hcnt_r + 4'h1;
          if (half_end) begin
            hcnt_r      <= 4'h0;
            tx_sh_r     <= tx_sh_nxt;
            bits_done_r <= bits_nxt;
            bit_cnt_r   <= byte_end ? 4'h0 : bit_nxt;
            if (desc_end && cur.last) begin
              // terminate only honoured on the final descriptor
              state_r <= cur.terminate_at_end ? sxd_pkg::ST_IDLE : sxd_pkg::ST_HOLD;
            end else if (desc_end) begin
              cur_idx_r   <= cur.next;
              bits_done_r <= 22'h0;
              bit_cnt_r   <= 4'h0;
              state_r     <= sxd_pkg::ST_LOAD;
            end else begin
              state_r <= byte_end ? sxd_pkg::ST_LOAD : sxd_pkg::ST_LO;
            end
          end
        end
        default: state_r <= sxd_pkg::ST_IDLE;
      endcase
    end
  end

  logic ev_rx;
  logic ev_tx;
  logic ev_done;
  assign ev_rx   = step_end && byte_end && cur.rx_en;
  assign ev_tx   = state_r == sxd_pkg::ST_LOAD && can_go && !stop_p &&
                   cur.tx_sel == sxd_pkg::TX_FIFO;
  assign ev_done = desc_end && cur.last && !stop_p;

  // transmit holding byte; a write while full is dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_data_r <= 8'h00;
      tx_full_r <= 1'b0;
    end else if (ev_tx) begin
      tx_full_r <= 1'b0;
    end else if (wr && adr_i == sxd_pkg::OFF_TXD && sel_i[0] && !tx_full_r) begin
      tx_data_r <= dat_i[7:0];
      tx_full_r <= 1'b1;
    end
  end

  // receive holding byte; the engine stalls rather than overwrite it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_data_r <= 8'h00;
      rx_full_r <= 1'b0;
    end else if (ev_rx && !stop_p) begin
      // the last lane sample was taken when the clock rose, so the shifter already holds the byte
      rx_data_r <= rx_sh_r;
      rx_full_r <= 1'b1;
    end else if (acc && !we_i && rd_took_r) begin
      rx_full_r <= 1'b0;
    end
  end

  // sticky events, write one to clear, a new event wins over the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_r <= '0;
    end else begin
      stat_r <= (stat_r & ~((wr && adr_i == sxd_pkg::OFF_STAT && sel_i[0]) ?
                dat_i[sxd_pkg::NEV-1:0] : 3'h0)) | {ev_tx, ev_rx, ev_done};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_r <= '0;
    end else if (wr && adr_i == sxd_pkg::OFF_MASK && sel_i[0]) begin
      mask_r <= dat_i[sxd_pkg::NEV-1:0];
    end
  end

  // descriptor file with byte enables
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < sxd_pkg::NDESC; i++) begin
        desc_r[i] <= sxd_pkg::DESC_RST;
      end
    end else if (wr && desc_hit) begin
      for (int b = 0; b < 4; b++) begin
        if (sel_i[b]) begin
          desc_r[wix[3:0]][b*8 +: 8] <= dat_i[b*8 +: 8];
        end
      end
    end
  end

  // read mux, captured in the cycle ack is raised
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    if (desc_hit) begin
      rd_mux = desc_r[wix[3:0]];
    end else begin
      case (adr_i)
        sxd_pkg::OFF_CTRL: rd_mux[sxd_pkg::CTRL_IDX_LSB +: 4] = cur_idx_r;
        sxd_pkg::OFF_STAT: begin
          rd_mux[sxd_pkg::NEV-1:0]         = stat_r;
          rd_mux[sxd_pkg::ST_ACTIVE]       = state_r != sxd_pkg::ST_IDLE;
          rd_mux[sxd_pkg::ST_CS]           = !cs_n_o;
          rd_mux[sxd_pkg::ST_CUR_LSB +: 4] = cur_idx_r;
        end
        sxd_pkg::OFF_MASK: rd_mux[sxd_pkg::NEV-1:0] = mask_r;
        sxd_pkg::OFF_TXD:  rd_mux[sxd_pkg::RXD_VALID] = tx_full_r;
        sxd_pkg::OFF_RXD:  rd_mux[sxd_pkg::RXD_VALID:0] = {rx_full_r, rx_data_r};
        default:           rd_mux = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r     <= 1'b0;
      dat_r     <= 32'h0;
      rd_took_r <= 1'b0;
    end else begin
      ack_r <= req && !ack_r;
      if (req && !ack_r) begin
        dat_r     <= rd_mux;
        // only a read that saw a full byte may empty it
        rd_took_r <= !we_i && adr_i == sxd_pkg::OFF_RXD && rx_full_r;
      end
    end
  end

  assign ack_o  = ack_r;
  assign dat_o  = dat_r;
  assign irq_o  = |(stat_r & mask_r);
  assign sclk_o = state_r == sxd_pkg::ST_HI;
  assign cs_n_o = state_r == sxd_pkg::ST_IDLE;

  always_comb begin
    io_o      = 4'h0;
    io_oe_n_o = 4'hf;
    case (cur.lanes)
      sxd_pkg::LN_DUAL: io_o = {2'h0, tx_sh_r[7:6]};
      sxd_pkg::LN_QUAD: io_o = tx_sh_r[7:4];
      default:          io_o = {3'h0, tx_sh_r[7]};
    endcase
    // tx select 0 leaves every lane to the slave or floating
    if (state_r != sxd_pkg::ST_IDLE && cur.tx_sel != sxd_pkg::TX_OFF) begin
      case (cur.lanes)
        sxd_pkg::LN_DUAL: io_oe_n_o = 4'hc;
        sxd_pkg::LN_QUAD: io_oe_n_o = 4'h0;
        default:          io_oe_n_o = 4'he;
      endcase
    end
  end

  // dma asks while the descriptor is live and the holding byte needs service
  assign tx_dma_req_o  = state_r != sxd_pkg::ST_IDLE && cur.tx_dma != 2'h0 &&
                         cur.tx_sel == sxd_pkg::TX_FIFO && !tx_full_r;
  assign rx_dma_req_o  = state_r != sxd_pkg::ST_IDLE && cur.rx_dma != 2'h0 &&
                         cur.rx_en && rx_full_r;
  assign tx_dma_size_o = cur.tx_dma;
  assign rx_dma_size_o = cur.rx_dma;

  property p_count_inf;
    @(posedge clk_i) disable iff (rst_i)
    (step_end && cur.count == 15'h0 && !dma_term_i && !stop_p) |=>
      (state_r == sxd_pkg::ST_LO || state_r == sxd_pkg::ST_LOAD);
  endproperty
  a_count_inf: assert property (p_count_inf) else $error("zero count ended");

  property p_done_last;
    @(posedge clk_i) disable iff (rst_i)
    (desc_end && cur.last && !stop_p) |=> stat_r[sxd_pkg::EV_DONE];
  endproperty
  a_done_last: assert property (p_done_last) else $error("done not set");

  property p_next;
    @(posedge clk_i) disable iff (rst_i)
    (desc_end && !cur.last && !stop_p) |=>
      state_r == sxd_pkg::ST_LOAD && cur_idx_r == $past(cur.next) && bits_done_r == 22'h0;
  endproperty
  a_next: assert property (p_next) else $error("successor not taken");

  property p_bytes;
    @(posedge clk_i) disable iff (rst_i)
    (desc_end && !dma_term_i && cur.unit == sxd_pkg::UNIT_BYTES &&
     cur.lanes == sxd_pkg::LN_SINGLE) |-> bits_nxt == {4'h0, cur.count, 3'h0};
  endproperty
  a_bytes: assert property (p_bytes) else $error("byte count wrong");

  property p_term;
    @(posedge clk_i) disable iff (rst_i)
    (desc_end && cur.last && cur.terminate_at_end) |=> cs_n_o && !tx_dma_req_o && !rx_dma_req_o;
  endproperty
  a_term: assert property (p_term) else $error("cs not released");

  property p_hold;
    @(posedge clk_i) disable iff (rst_i)
    (desc_end && cur.last && !cur.terminate_at_end && !stop_p) |=>
      !cs_n_o ##1 (!cs_n_o || $past(stop_p));
  endproperty
  a_hold: assert property (p_hold) else $error("cs dropped");

  property p_rx_off;
    @(posedge clk_i) disable iff (rst_i)
    (state_r == sxd_pkg::ST_HI && !cur.rx_en && !rx_full_r) |=> !rx_full_r;
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("rx stored while off");

  property p_tx_const;
    @(posedge clk_i) disable iff (rst_i)
    (state_r == sxd_pkg::ST_LOAD && can_go && !stop_p && cur.tx_sel == sxd_pkg::TX_ONE &&
     cur.lanes == sxd_pkg::LN_SINGLE) |=> io_o[0] && !io_oe_n_o[0];
  endproperty
  a_tx_const: assert property (p_tx_const) else $error("ones not driven");

  property p_tx_fifo;
    @(posedge clk_i) disable iff (rst_i)
    ev_tx |=> !tx_full_r && tx_sh_r == $past(tx_data_r);
  endproperty
  a_tx_fifo: assert property (p_tx_fifo) else $error("fifo byte not sent");

  property p_tx_off;
    @(posedge clk_i) disable iff (rst_i)
    (cur.tx_sel == sxd_pkg::TX_OFF) |-> io_oe_n_o == 4'hf;
  endproperty
  a_tx_off: assert property (p_tx_off) else $error("line driven while off");

  c_done:  cover property (@(posedge clk_i) disable iff (rst_i) ev_done);
  c_hold:  cover property (@(posedge clk_i) disable iff (rst_i) state_r == sxd_pkg::ST_HOLD);
  c_chain: cover property (@(posedge clk_i) disable iff (rst_i) desc_end && !cur.last);
  c_rx:    cover property (@(posedge clk_i) disable iff (rst_i) ev_rx);
endmodule
`default_nettype wire

// *** rtl/sxd_pkg.sv ***
// shared constants, descriptor layout and states of the transfer-descriptor spi engine
package sxd_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL  = 8'h00;
  localparam logic [7:0] OFF_STAT  = 8'h04;
  localparam logic [7:0] OFF_MASK  = 8'h08;
  localparam logic [7:0] OFF_TXD   = 8'h0c;
  localparam logic [7:0] OFF_RXD   = 8'h10;
  localparam logic [7:0] OFF_DESC0 = 8'h30;
  localparam int unsigned NDESC    = 16;
  localparam logic [5:0] NDESC_W   = 6'h10;

  // control word fields
  localparam int unsigned CTRL_START   = 0;
  localparam int unsigned CTRL_STOP    = 1;
  localparam int unsigned CTRL_IDX_LSB = 4;

  // status / mask layout
  localparam int unsigned EV_DONE    = 0;
  localparam int unsigned EV_RX      = 1;
  localparam int unsigned EV_TX      = 2;
  localparam int unsigned NEV        = 3;
  localparam int unsigned ST_ACTIVE  = 8;
  localparam int unsigned ST_CS      = 9;
  localparam int unsigned ST_CUR_LSB = 12;
  localparam int unsigned RXD_VALID  = 8;

  // one descriptor word, msb first
  typedef struct packed {
    logic [14:0] count;
    logic        last;
    logic [3:0]  next;
    logic [1:0]  unit;
    logic        terminate_at_end;
    logic [1:0]  rx_dma;
    logic        rx_en;
    logic [1:0]  tx_dma;
    logic [1:0]  tx_sel;
    logic [1:0]  lanes;
  } sxd_desc_t;
  localparam logic [31:0] DESC_RST = 32'h0;

  localparam logic [1:0] UNIT_BITS  = 2'h0;
  localparam logic [1:0] UNIT_BYTES = 2'h1;
  localparam logic [1:0] UNIT_SEG4  = 2'h2;
  localparam logic [1:0] UNIT_SEG16 = 2'h3;
  localparam logic [2:0] SH_BITS    = 3'h0;
  localparam logic [2:0] SH_BYTES   = 3'h3;
  localparam logic [2:0] SH_SEG4    = 3'h5;
  localparam logic [2:0] SH_SEG16   = 3'h7;

  localparam logic [1:0] TX_OFF  = 2'h0;
  localparam logic [1:0] TX_FIFO = 2'h1;
  localparam logic [1:0] TX_ZERO = 2'h2;
  localparam logic [1:0] TX_ONE  = 2'h3;

  localparam logic [1:0] LN_SINGLE = 2'h0;
  localparam logic [1:0] LN_DUAL   = 2'h1;
  localparam logic [1:0] LN_QUAD   = 2'h2;
  localparam logic [3:0] STEP1     = 4'h1;
  localparam logic [3:0] STEP2     = 4'h2;
  localparam logic [3:0] STEP4     = 4'h4;

  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] SCK_HALF  = 4'h2;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LOAD,
    ST_LO,
    ST_HI,
    ST_HOLD
  } sxd_state_t;
endpackage

// *** dv/sxd_slave.sv ***
// behavioural spi slave at the far side: answers a byte, counts clocks, captures lane 0
`timescale 1ns/1ps
`default_nettype none
module sxd_slave (
  input  wire logic        clk_i,
  input  wire logic        sclk_i,
  input  wire logic        cs_n_i,
  input  wire logic [3:0]  dout_i,
  input  wire logic [3:0]  oe_n_i,
  input  wire logic [7:0]  byte_i,
  output logic      [3:0]  wire_o,
  output logic      [15:0] cnt_o,
  output logic      [15:0] mosi_o,
  output logic             drv_o
);
  logic [7:0] sh_r;
  logic [3:0] last_r;
  initial begin
    sh_r = 8'h00;
    last_r = 4'h0;
    cnt_o = 16'h0000;
    mosi_o = 16'h0000;
    drv_o = 1'b0;
  end
  // a new frame restarts the reply byte and all counters
  always @(negedge cs_n_i) begin
    sh_r = byte_i;
    cnt_o = 16'h0000;
    mosi_o = 16'h0000;
    drv_o = 1'b0;
  end
  // mode 0: the next reply bit goes out while the clock is low
  always @(negedge sclk_i) begin
    if (!cs_n_i) begin
      sh_r = {sh_r[6:0], ~sh_r[7]};
    end
  end
  always @(posedge sclk_i) begin
    if (!cs_n_i) begin
      cnt_o = cnt_o + 16'h0001;
      mosi_o = {mosi_o[14:0], wire_o[0]};
      drv_o = drv_o | (oe_n_i != 4'hf);
    end
  end
  // released lines never keep the last level, so a stale sample cannot pass
  always @(posedge clk_i) begin
    last_r <= wire_o;
  end
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      if (!oe_n_i[k]) wire_o[k] = dout_i[k];
      else if (k == 1 && !cs_n_i) wire_o[k] = sh_r[7];
      else wire_o[k] = ~last_r[k];
    end
  end
endmodule
`default_nettype wire

// *** dv/sxd_top_tb_top.sv ***
// self-checking bench: wishbone register traffic and spi frames against a slave model
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
  $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module sxd_top_tb_top;
  typedef struct packed {
    logic [31:0] v;
    logic [31:0] m;
  } sxd_exp_t;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, sclk_o, cs_n_o, drv, ir;
  logic        tx_dma_req_o, rx_dma_req_o, dma_term_i, irq_o;
  logic [7:0]  adr_i, rbyte;
  logic [3:0]  sel_i, io_o, io_oe_n_o, io_i, ts;
  logic [31:0] dat_i, dat_o, lf;
  logic [1:0]  tx_dma_size_o, rx_dma_size_o;
  logic [15:0] cnt, mosi;
  int          checks, fails, n;
  int          ub[4] = '{1, 8, 32, 128};
  sxd_exp_t    exq[$];
  sxd_exp_t    e;

  sxd_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .sclk_o(sclk_o), .cs_n_o(cs_n_o), .io_o(io_o), .io_oe_n_o(io_oe_n_o), .io_i(io_i),
    .tx_dma_req_o(tx_dma_req_o), .rx_dma_req_o(rx_dma_req_o), .tx_dma_size_o(tx_dma_size_o),
    .rx_dma_size_o(rx_dma_size_o), .dma_term_i(dma_term_i), .irq_o(irq_o));
  sxd_slave u_slv (.clk_i(clk_i), .sclk_i(sclk_o), .cs_n_i(cs_n_o), .dout_i(io_o),
    .oe_n_i(io_oe_n_o), .byte_i(rbyte), .wire_o(io_i), .cnt_o(cnt), .mosi_o(mosi),
    .drv_o(drv));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // rx is {dma size, enable}, tx is {dma size, select}
  function automatic logic [31:0] dsc(input logic [14:0] c, input logic l, input logic [3:0] nt,
      input logic [1:0] u, input logic t, input logic [2:0] rx, input logic [3:0] tx);
    sxd_pkg::sxd_desc_t x;
    x = {c, l, nt, u, t, rx, tx, sxd_pkg::LN_SINGLE};
    return x;
  endfunction

  task automatic close_out;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic tmo(input string w);
    fails++;
    $display("unexpected %s exp done got timeout", w);
    close_out();
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 20);
    if (ack_o !== 1'b1) tmo("ack");
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m);
    exq.push_back('{v & m, m});
    wb(1'b0, a, 32'h0);
  endtask
  task automatic wd(input logic [3:0] i, input logic [31:0] d);
    wr(sxd_pkg::OFF_DESC0 + {2'h0, i, 2'h0}, d);
  endtask
  task automatic go(input logic [3:0] i);
    wr(sxd_pkg::OFF_CTRL, {24'h0, i, 4'h1});
  endtask
  task automatic clr;
    wr(sxd_pkg::OFF_STAT, 32'h7);
  endtask
  // w selects the awaited event: 0 clock count, 1 irq, 2 tx request, 3 end of frame
  task automatic hold(input int w, input logic [15:0] k);
    for (n = 0; n < 20000; n++) begin
      if (w == 0 ? cnt >= k : w == 1 ? irq_o === 1'b1 : w == 2 ? tx_dma_req_o === 1'b1
          : cs_n_o === 1'b1) break;
      ir |= (irq_o === 1'b1);
      @(posedge clk_i);
    end
    if (n >= 20000) tmo("wait");
  endtask
  task automatic run(input logic [3:0] i);
    go(i);
    ir = 1'b0;
    hold(3, 16'h0);
  endtask

  // read results are compared as they come back, oldest note first
  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && we_i === 1'b0 && exq.size() > 0) begin
      e = exq.pop_front();
      `CHK("read data", e.v, dat_o & e.m)
    end
  end

  initial begin
    {cyc_i, stb_i, we_i, dma_term_i, ir} = 5'h00;
    adr_i = 8'h00;
    sel_i = 4'hf;
    dat_i = 32'h0;
    rbyte = 8'h00;
    rst_i = 1'b1;
    lf = 32'h00017d00;
    checks = 0;
    fails = 0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(sxd_pkg::OFF_STAT, 32'h0, 32'hffffffff);
    rd(8'hfc, 32'h0, 32'hffffffff);
    `CHK("irq", 1'b0, irq_o)
    for (int i = 0; i < 16; i++) begin
      rd(sxd_pkg::OFF_DESC0 + 8'(4 * i), sxd_pkg::DESC_RST, 32'hffffffff);
      lf = nx(lf);
      wd(4'(i), lf);
      rd(sxd_pkg::OFF_DESC0 + 8'(4 * i), lf, 32'hffffffff);
    end
    wr(sxd_pkg::OFF_MASK, 32'h1);
    for (int u = 0; u < 4; u++) begin
      ts = (u % 2) ? {2'h0, sxd_pkg::TX_ONE} : {2'h0, sxd_pkg::TX_ZERO};
      wd(4'h0, dsc(15'h8, 1'b1, 4'h0, 2'(u), 1'b1, 3'h0, ts));
      run(4'h0);
      `CHK("clock count", 16'(8 * ub[u]), cnt)
      `CHK("lane 0 data", (u % 2) ? 8'hff : 8'h00, mosi[7:0])
      `CHK("chip select", 1'b1, cs_n_o)
      `CHK("lane enables", 4'hf, io_oe_n_o)
      rd(sxd_pkg::OFF_STAT, 32'h1, 32'h301);
      `CHK("irq", 1'b1, irq_o)
      clr();
      @(posedge clk_i);
      `CHK("irq", 1'b0, irq_o)
    end
    rd(sxd_pkg::OFF_RXD, 32'h0, 32'h100);
    wd(4'h0, dsc(15'h8, 1'b1, 4'h0, 2'h0, 1'b1, 3'h0, 4'h0));
    run(4'h0);
    `CHK("lanes driven", 1'b0, drv)
    clr();
    wd(4'h1, dsc(15'h8, 1'b0, 4'h2, 2'h0, 1'b0, 3'h0, 4'h3));
    wd(4'h2, dsc(15'h8, 1'b1, 4'h1, 2'h0, 1'b1, 3'h0, 4'h2));
    run(4'h1);
    `CHK("irq before chain end", 1'b0, ir)
    `CHK("chain data", 16'hff00, mosi)
    rd(sxd_pkg::OFF_STAT, 32'h1, 32'h7);
    clr();
    wd(4'h3, dsc(15'h4, 1'b0, 4'h3, 2'h0, 1'b0, 3'h0, 4'h2));
    go(4'h3);
    hold(0, 16'h28);
    `CHK("chip select in loop", 1'b0, cs_n_o)
    rd(sxd_pkg::OFF_STAT, 32'h0, 32'h1);
    wr(sxd_pkg::OFF_CTRL, 32'h2);
    @(posedge clk_i);
    `CHK("chip select after stop", 1'b1, cs_n_o)
    wd(4'h4, dsc(15'h4, 1'b1, 4'h0, 2'h0, 1'b0, 3'h0, 4'h2));
    go(4'h4);
    hold(1, 16'h0);
    rd(sxd_pkg::OFF_STAT, 32'h301, 32'h301);
    `CHK("chip select held", 1'b0, cs_n_o)
    wr(sxd_pkg::OFF_CTRL, 32'h2);
    clr();
    wd(4'h5, dsc(15'h0, 1'b1, 4'h0, 2'h1, 1'b1, 3'h0, 4'h2));
    go(4'h5);
    hold(0, 16'h100);
    `CHK("endless frame", 1'b0, cs_n_o)
    dma_term_i <= 1'b1;
    hold(3, 16'h0);
    dma_term_i <= 1'b0;
    rd(sxd_pkg::OFF_STAT, 32'h1, 32'h1);
    clr();
    for (int s = 1; s < 4; s++) begin
      lf = nx(lf);
      rbyte <= lf[7:0];
      wd(4'h6, dsc(15'h8, 1'b1, 4'h0, 2'h0, 1'b0, {2'(s), 1'b1}, 4'h2));
      go(4'h6);
      hold(1, 16'h0);
      `CHK("rx dma size", 2'(s), rx_dma_size_o)
      `CHK("rx dma request", 1'b1, rx_dma_req_o)
      rd(sxd_pkg::OFF_RXD, {23'h0, 1'b1, lf[7:0]}, 32'h1ff);
      @(posedge clk_i);
      `CHK("rx dma request", 1'b0, rx_dma_req_o)
      wr(sxd_pkg::OFF_CTRL, 32'h2);
      clr();
    end
    // dual then quad, transmit only: fewer clocks for the same bit count
    for (int l = 1; l < 3; l++) begin
      wd(4'h8, dsc(15'h8, 1'b1, 4'h0, 2'h0, 1'b1, 3'h0, 4'h3) | 32'(l));
      run(4'h8);
      `CHK("lane clocks", 16'(8 / (2 * l)), cnt)
      `CHK("lane 0 data", 2'h3, mosi[1:0])
      `CHK("lanes driven", 1'b1, drv)
      clr();
    end
    wr(sxd_pkg::OFF_MASK, 32'h0);
    wd(4'h7, dsc(15'h8, 1'b1, 4'h0, 2'h0, 1'b1, 3'h0, 4'h5));
    go(4'h7);
    hold(2, 16'h0);
    `CHK("tx dma size", 2'h1, tx_dma_size_o)
    `CHK("clocks while starved", 16'h0, cnt)
    lf = nx(lf);
    wr(sxd_pkg::OFF_TXD, {24'h0, lf[7:0]});
    hold(3, 16'h0);
    `CHK("tx byte", lf[7:0], mosi[7:0])
    `CHK("irq masked", 1'b0, irq_o)
    wr(sxd_pkg::OFF_MASK, 32'h1);
    @(posedge clk_i);
    `CHK("irq unmasked", 1'b1, irq_o)
    clr();
    @(posedge clk_i);
    `CHK("irq cleared", 1'b0, irq_o)
    close_out();
  end
endmodule
`default_nettype wire
